// ==== inc/sct_cfg.svh ====
// constants and register map of the sample clock trim and slot enable block
// Overview of operation
// - slot A runs while its enable bit is set
// - trigger source picks slow tick or aux pin
// - bypass takes time base from aux pin one while its input enable bit is set
// - pin control bits drive pin one enables
// - sample clock enable gates the sample clock
// - slow trim steps 0.6 kHz per unit
// - larger slow trim code means lower frequency
// - slow trim resets to 0x12
// - fast trim steps 109 kHz per unit
// - larger fast trim code means higher frequency
`ifndef SCT_CFG_SVH
`define SCT_CFG_SVH

// register addresses as printed
`define SCT_ADDR_SLOT_CFG      8'h11
`define SCT_ADDR_STARTUP_WORD  8'h38
`define SCT_ADDR_SLOW_CLK      8'h4B
`define SCT_ADDR_FAST_TRIM     8'h4D
`define SCT_ADDR_PIN_CTRL      8'h4F

// reset values
`define SCT_RST_SLOT_CFG       16'h0000
`define SCT_RST_STARTUP_WORD   16'h0000
`define SCT_RST_SLOW_CLK       16'h2612
`define SCT_RST_FAST_TRIM      16'h0098
`define SCT_RST_PIN_CTRL       16'h2090
`define SCT_RST_SLOW_FREQ      17'h0A280
`define SCT_RST_FAST_FREQ      16'h7D00
`define SCT_ZERO16             16'h0000

// field positions
`define SCT_BIT_SLOT_A_EN      0
`define SCT_BIT_SLOW_BYPASS    8
`define SCT_BIT_SCLK_EN        7
`define SCT_SLOW_TRIM_MSB      5
`define SCT_FAST_TRIM_MSB      7
`define SCT_BIT_PIN1_OE        6
`define SCT_BIT_PIN1_IE        5
`define SCT_TRIG_SEL_MSB       3
`define SCT_TRIG_SEL_LSB       2

// frequency model: slow in Hz, fast in kHz
`define SCT_SLOW_TOP_HZ        52400
`define SCT_SLOW_STEP_HZ       600
`define SCT_FAST_BASE_KHZ      15432
`define SCT_FAST_STEP_KHZ      109

// slow trim centre point: nominal sample master clock
`define SCT_SLOW_CENTRE_CODE   6'h22
`define SCT_SLOW_CENTRE_HZ     17'h07D00

`endif

// ==== inc/sct_pkg.sv ====
// types shared by the sample clock trim and slot enable block
package sct_pkg;

  // one register access from the serial control port
  typedef struct packed {
    logic [7:0]  addr;   // register address
    logic [15:0] wdata;  // write data
    logic        wr;     // write strobe, one cycle
    logic        rd;     // read strobe, one cycle
  } sct_reg_req_t;

  // sample cycle start source
  typedef enum logic [1:0] {
    SCT_TRIG_SLOW = 2'h0,
    SCT_TRIG_PIN0 = 2'h1,
    SCT_TRIG_PIN1 = 2'h2,
    SCT_TRIG_RSVD = 2'h3
  } sct_trig_t;

endpackage : sct_pkg

// ==== src/sct_top.sv ====
// register file and clock steering of the sample timing core
`timescale 1ns/1ps
`include "sct_cfg.svh"

module sct_top (
  input  wire logic                 clock_in,            // 100 MHz
  input  wire logic                 rst_in,              // sync, active high
  input  wire sct_pkg::sct_reg_req_t reg_req_in,         // serial port access
  input  wire logic                 slow_osc_in,         // internal slow clock level
  input  wire logic                 slow_tick_in,        // internal sample rate tick
  input  wire logic                 aux_pin_zero_in,     // pin zero level
  input  wire logic                 aux_pin_one_in,      // pin one level
  output logic [15:0]               reg_rdata_out,       // read data
  output logic                      reg_rvalid_out,      // read data valid pulse
  output logic                      slot_a_run_out,      // slot A runs
  output logic                      sample_clock_out,    // gated sample time base
  output logic                      sample_start_out,    // sample cycle start pulse
  output logic [5:0]                slow_osc_trim_out,   // slow trim code
  output logic [7:0]                fast_osc_trim_out,   // fast trim code
  output logic [16:0]               slow_osc_freq_out,   // estimated slow freq, Hz
  output logic [15:0]               fast_osc_freq_out,   // estimated fast freq, kHz
  output logic                      aux_pin_one_out,     // pin one drive value
  output logic                      aux_pin_one_oe_n_out // low while pin one driven
);

  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic [15:0] slot_cfg;        // slot configuration
  logic [15:0] startup_word;    // sync trigger startup word
  logic [15:0] slow_clk;        // slow clock control
  logic [15:0] fast_trim;       // fast clock trim
  logic [15:0] pin_ctrl;        // pin control
  logic [15:0] rdata;           // read data register
  logic        rvalid;          // read valid register
  logic [15:0] next_slot_cfg;
  logic [15:0] next_startup_word;
  logic [15:0] next_slow_clk;
  logic [15:0] next_fast_trim;
  logic [15:0] next_pin_ctrl;
  logic [15:0] next_rdata;
  logic        next_rvalid;

  // write decode and read mux; reserved bits are stored as written
  always_comb begin
    next_slot_cfg     = slot_cfg;
    next_startup_word = startup_word;
    next_slow_clk     = slow_clk;
    next_fast_trim    = fast_trim;
    next_pin_ctrl     = pin_ctrl;
    next_rdata        = rdata;
    next_rvalid       = reg_req_in.rd;
    if (reg_req_in.wr) begin
      case (reg_req_in.addr)
        `SCT_ADDR_SLOT_CFG:     next_slot_cfg     = reg_req_in.wdata;
        `SCT_ADDR_STARTUP_WORD: next_startup_word = reg_req_in.wdata;
        `SCT_ADDR_SLOW_CLK:     next_slow_clk     = reg_req_in.wdata;
        `SCT_ADDR_FAST_TRIM:    next_fast_trim    = reg_req_in.wdata;
        `SCT_ADDR_PIN_CTRL:     next_pin_ctrl     = reg_req_in.wdata;
        default: begin
          // unmapped writes are dropped
        end
      endcase
    end
    if (reg_req_in.rd) begin
      case (reg_req_in.addr)
        `SCT_ADDR_SLOT_CFG:     next_rdata = slot_cfg;
        `SCT_ADDR_STARTUP_WORD: next_rdata = startup_word;
        `SCT_ADDR_SLOW_CLK:     next_rdata = slow_clk;
        `SCT_ADDR_FAST_TRIM:    next_rdata = fast_trim;
        `SCT_ADDR_PIN_CTRL:     next_rdata = pin_ctrl;
        default:                next_rdata = `SCT_ZERO16; // unmapped reads zero
      endcase
    end
  end

  // register state
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      slot_cfg     <= `SCT_RST_SLOT_CFG;
      startup_word <= `SCT_RST_STARTUP_WORD;
      slow_clk     <= `SCT_RST_SLOW_CLK;
      fast_trim    <= `SCT_RST_FAST_TRIM;
      pin_ctrl     <= `SCT_RST_PIN_CTRL;
      rdata        <= `SCT_ZERO16;
      rvalid       <= 1'b0;
    end else begin
      slot_cfg     <= next_slot_cfg;
      startup_word <= next_startup_word;
      slow_clk     <= next_slow_clk;
      fast_trim    <= next_fast_trim;
      pin_ctrl     <= next_pin_ctrl;
      rdata        <= next_rdata;
      rvalid       <= next_rvalid;
    end
  end

  // fields that leave as outputs are the register flops themselves, except pin one enable, which leaves inverted
  assign reg_rdata_out        = rdata;
  assign reg_rvalid_out       = rvalid;
  assign slot_a_run_out       = slot_cfg[`SCT_BIT_SLOT_A_EN];
  assign slow_osc_trim_out    = slow_clk[`SCT_SLOW_TRIM_MSB:0];
  assign fast_osc_trim_out    = fast_trim[`SCT_FAST_TRIM_MSB:0];
  assign aux_pin_one_oe_n_out = ~pin_ctrl[`SCT_BIT_PIN1_OE];

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; stage one feeds stage two only
  logic [2:0] pin0_sync;  // [0] meta, [1] stable, [2] previous
  logic [2:0] pin1_sync;
  logic [2:0] next_pin0_sync;
  logic [2:0] next_pin1_sync;

  always_comb begin
    next_pin0_sync = {pin0_sync[1:0], aux_pin_zero_in};
    next_pin1_sync = {pin1_sync[1:0], aux_pin_one_in};
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pin0_sync <= 3'h0;
      pin1_sync <= 3'h0;
    end else begin
      pin0_sync <= next_pin0_sync;
      pin1_sync <= next_pin1_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock steering and trigger selection
  logic              sclk;         // gated sample time base
  logic              sstart;       // sample cycle start
  logic              pin1_drv;     // pin one drive value
  logic [16:0]       slow_freq;    // Hz estimate
  logic [15:0]       fast_freq;    // kHz estimate
  logic              next_sclk;
  logic              next_sstart;
  logic [16:0]       next_slow_freq;
  logic [15:0]       next_fast_freq;
  logic              pin1_ie;      // pin one input path open
  logic              pin0_rise;
  logic              pin1_rise;
  sct_pkg::sct_trig_t trig_sel;
  logic [31:0]       slow_calc;
  logic [31:0]       fast_calc;

  always_comb begin
    pin1_ie   = pin_ctrl[`SCT_BIT_PIN1_IE];
    pin0_rise = pin0_sync[1] & ~pin0_sync[2];
    pin1_rise = pin1_ie & pin1_sync[1] & ~pin1_sync[2];
    trig_sel  = sct_pkg::sct_trig_t'(pin_ctrl[`SCT_TRIG_SEL_MSB:`SCT_TRIG_SEL_LSB]);
    // time base: internal oscillator or pin one; the input path must be open,
    // which software arranges before relying on bypass
    if (slow_clk[`SCT_BIT_SLOW_BYPASS]) begin
      next_sclk = pin1_ie & pin1_sync[1];
    end else begin
      next_sclk = slow_osc_in;
    end
    next_sclk = next_sclk & slow_clk[`SCT_BIT_SCLK_EN];
    // sample cycle start only while the sample clock is powered
    case (trig_sel)
      sct_pkg::SCT_TRIG_SLOW: next_sstart = slow_tick_in;
      sct_pkg::SCT_TRIG_PIN0: next_sstart = pin0_rise;
      sct_pkg::SCT_TRIG_PIN1: next_sstart = pin1_rise;
      default:                next_sstart = 1'b0; // reserved: no trigger
    endcase
    next_sstart = next_sstart & slow_clk[`SCT_BIT_SCLK_EN];
    // frequency estimates; slow falls with code, fast rises with code
    slow_calc = `SCT_SLOW_TOP_HZ - (32'(slow_clk[`SCT_SLOW_TRIM_MSB:0])
                * `SCT_SLOW_STEP_HZ);
    fast_calc = `SCT_FAST_BASE_KHZ + (32'(fast_trim[`SCT_FAST_TRIM_MSB:0])
                * `SCT_FAST_STEP_KHZ);
    next_slow_freq = slow_calc[16:0];
    next_fast_freq = fast_calc[15:0];
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sclk      <= 1'b0;
      sstart    <= 1'b0;
      pin1_drv  <= 1'b0;
      slow_freq <= `SCT_RST_SLOW_FREQ;
      fast_freq <= `SCT_RST_FAST_FREQ;
    end else begin
      sclk      <= next_sclk;
      sstart    <= next_sstart;
      pin1_drv  <= 1'b0; // pin one only ever driven low here
      slow_freq <= next_slow_freq;
      fast_freq <= next_fast_freq;
    end
  end

  assign sample_clock_out  = sclk;
  assign sample_start_out  = sstart;
  assign aux_pin_one_out   = pin1_drv;
  assign slow_osc_freq_out = slow_freq;
  assign fast_osc_freq_out = fast_freq;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  a_slot_write_run: assert property (
    reg_req_in.wr && reg_req_in.addr == `SCT_ADDR_SLOT_CFG
    |=> slot_a_run_out == $past(reg_req_in.wdata[`SCT_BIT_SLOT_A_EN]))
    else $error("slot A run does not follow write");
  a_trim_reset_val: assert property (
    $past(rst_in) |-> slow_osc_trim_out == 6'(`SCT_RST_SLOW_CLK)
    && fast_osc_trim_out == 8'(`SCT_RST_FAST_TRIM))
    else $error("trim reset value wrong");
  a_sclk_gated_off: assert property (
    !slow_clk[`SCT_BIT_SCLK_EN] ##1 !slow_clk[`SCT_BIT_SCLK_EN]
    |-> !sample_clock_out && !sample_start_out)
    else $error("sample clock not gated");
  a_bypass_pin_one: assert property (
    slow_clk[`SCT_BIT_SLOW_BYPASS] && slow_clk[`SCT_BIT_SCLK_EN] && pin_ctrl[`SCT_BIT_PIN1_IE]
    |=> sample_clock_out == $past(pin1_sync[1]))
    else $error("bypass does not follow pin one");
  a_internal_osc: assert property (
    !slow_clk[`SCT_BIT_SLOW_BYPASS] && slow_clk[`SCT_BIT_SCLK_EN]
    |=> sample_clock_out == $past(slow_osc_in, 1))
    else $error("internal oscillator not used");
  a_pin0_trigger: assert property (
    trig_sel == sct_pkg::SCT_TRIG_PIN0 && slow_clk[`SCT_BIT_SCLK_EN] && $rose(pin0_sync[1])
    |=> sample_start_out)
    else $error("pin zero edge lost");
  a_reserved_trig: assert property (
    trig_sel == sct_pkg::SCT_TRIG_RSVD |=> !sample_start_out)
    else $error("reserved source started a sample");
  a_slow_trim_order: assert property (
    $stable(slow_clk) [*2] ##0 slow_osc_trim_out == `SCT_SLOW_CENTRE_CODE
    |-> slow_osc_freq_out == `SCT_SLOW_CENTRE_HZ)
    else $error("slow centre frequency wrong");
  // both trims held two cycles: both estimates must have settled on their codes
  a_fast_trim_order: assert property (
    ($stable(fast_trim) && $stable(slow_clk)) [*2]
    |-> fast_osc_freq_out == 16'(`SCT_FAST_BASE_KHZ + `SCT_FAST_STEP_KHZ * fast_osc_trim_out)
    && slow_osc_freq_out == 17'(`SCT_SLOW_TOP_HZ - `SCT_SLOW_STEP_HZ * slow_osc_trim_out))
    else $error("trim frequency mapping wrong");
  a_pin1_oe_drive: assert property (
    pin_ctrl[`SCT_BIT_PIN1_OE] |-> !aux_pin_one_oe_n_out ##0 !aux_pin_one_out)
    else $error("pin one enable wrong");
  // any address outside the map reads back zero with a valid pulse
  a_unmapped_read: assert property (
    reg_req_in.rd && !(reg_req_in.addr inside {`SCT_ADDR_SLOT_CFG, `SCT_ADDR_STARTUP_WORD,
    `SCT_ADDR_SLOW_CLK, `SCT_ADDR_FAST_TRIM, `SCT_ADDR_PIN_CTRL})
    |=> reg_rvalid_out && reg_rdata_out == `SCT_ZERO16)
    else $error("unmapped read not zero");

  c_bypass_on:   cover property (slow_clk[`SCT_BIT_SLOW_BYPASS] && slow_clk[`SCT_BIT_SCLK_EN]
                                 && sample_clock_out);
  c_pin1_start:  cover property (trig_sel == sct_pkg::SCT_TRIG_PIN1 && sample_start_out);
  c_slot_a_run:  cover property ($rose(slot_a_run_out));
  c_trim_write:  cover property ($changed(fast_osc_trim_out));

endmodule : sct_top

// ==== tb/sct_bench.sv ====
// self-checking bench of the sample clock trim and slot enable block
`timescale 1ns/1ps
`include "sct_cfg.svh"

module sct_bench;
  logic                  clock_in = 1'b0;  // 100 MHz
  logic                  rst_in   = 1'b1;  // sync reset
  sct_pkg::sct_reg_req_t req      = '0;    // register access
  logic                  slow_osc = 1'b0;  // internal slow clock level
  logic                  slow_tick = 1'b0; // sample rate tick
  logic                  pin0     = 1'b0;  // aux pin zero
  logic                  pin1     = 1'b0;  // aux pin one
  logic [15:0]           rdata;
  logic                  rvalid, slot_a, sclk, start, pin1_drv, oe_n;
  logic [5:0]            s_trim;
  logic [7:0]            f_trim;
  logic [16:0]           s_freq;
  logic [15:0]           f_freq;
  int                    n_mismatch = 0;
  int                    cmp_count  = 0;
  logic [5:0]            s_codes [3] = '{6'h00, 6'h22, 6'h3F}; // max, centre, min
  logic [7:0]            f_codes [3] = '{8'h00, 8'h98, 8'hFF}; // min, default, max

  always #5 clock_in = ~clock_in;

  sct_top i_sct_top (
    .clock_in(clock_in), .rst_in(rst_in), .reg_req_in(req), .slow_osc_in(slow_osc),
    .slow_tick_in(slow_tick), .aux_pin_zero_in(pin0), .aux_pin_one_in(pin1),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .slot_a_run_out(slot_a),
    .sample_clock_out(sclk), .sample_start_out(start), .slow_osc_trim_out(s_trim),
    .fast_osc_trim_out(f_trim), .slow_osc_freq_out(s_freq), .fast_osc_freq_out(f_freq),
    .aux_pin_one_out(pin1_drv), .aux_pin_one_oe_n_out(oe_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // one compare for every result, widened to the widest output
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // write strobe held for exactly one edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    req.addr  = a;
    req.wdata = d;
    req.wr    = 1'b1;
    @(negedge clock_in);
    req.wr = 1'b0;
    @(negedge clock_in);
  endtask : wr

  // read answer is registered on the taking edge and checked at the next falling edge; an idle edge follows
  // so that back-to-back calls never move the strobe twice in one step
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    req.addr = a;
    req.rd   = 1'b1;
    @(negedge clock_in);
    req.rd = 1'b0;
    chk({16'h0000, rvalid}, 17'h00001);
    chk({1'b0, rdata}, {1'b0, exp});
    @(negedge clock_in);
  endtask : rd

  // bounded watch for a start pulse; the tick is dropped after one edge
  task automatic wait_start(input int n, input logic exp);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < n; i++) begin
      @(negedge clock_in);
      slow_tick = 1'b0;
      seen |= start;
    end
    chk({16'h0000, seen}, {16'h0000, exp});
  endtask : wait_start

  // sample clock level after a settle time
  task automatic clk_chk(input int n, input logic exp);
    repeat (n) @(negedge clock_in);
    chk({16'h0000, sclk}, {16'h0000, exp});
  endtask : clk_chk

  task automatic test_end(input string name);
    $display("test %s done, mismatches so far %0d", name, n_mismatch);
  endtask : test_end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////
  // main sequence, inputs move on the falling edge only
  initial begin
    repeat (4) @(negedge clock_in);
    rst_in = 1'b0;
    rd(`SCT_ADDR_SLOT_CFG, 16'h0000);
    rd(`SCT_ADDR_STARTUP_WORD, 16'h0000);
    rd(`SCT_ADDR_SLOW_CLK, 16'h2612);
    rd(`SCT_ADDR_FAST_TRIM, 16'h0098);
    rd(`SCT_ADDR_PIN_CTRL, 16'h2090);
    chk({11'h000, s_trim}, 17'h00012);
    chk({9'h000, f_trim}, 17'h00098);
    chk({16'h0000, oe_n}, 17'h00001);
    rd(8'h20, 16'h0000);
    test_end("reset");
    // slot A follows bit 0 both ways
    wr(`SCT_ADDR_SLOT_CFG, 16'h0001);
    chk({16'h0000, slot_a}, 17'h00001);
    rd(`SCT_ADDR_SLOT_CFG, 16'h0001);
    wr(`SCT_ADDR_SLOT_CFG, 16'h0000);
    chk({16'h0000, slot_a}, 17'h00000);
    wr(`SCT_ADDR_STARTUP_WORD, 16'h4000);
    rd(`SCT_ADDR_STARTUP_WORD, 16'h4000);
    test_end("slot and startup");
    // trim codes at both ends, plus the slow centre and the fast default
    for (int i = 0; i < 3; i++) begin
      wr(`SCT_ADDR_SLOW_CLK, 16'h2600 | {10'h000, s_codes[i]});
      chk({11'h000, s_trim}, {11'h000, s_codes[i]});
      chk(s_freq, 17'(`SCT_SLOW_TOP_HZ - `SCT_SLOW_STEP_HZ * s_codes[i]));
      wr(`SCT_ADDR_FAST_TRIM, {8'h00, f_codes[i]});
      chk({9'h000, f_trim}, {9'h000, f_codes[i]});
      chk({1'b0, f_freq}, 17'(`SCT_FAST_BASE_KHZ + `SCT_FAST_STEP_KHZ * f_codes[i]));
    end
    test_end("trim");
    // clock and start held off until the enable is set
    wr(`SCT_ADDR_SLOW_CLK, 16'h2612);
    slow_osc = 1'b1;
    clk_chk(3, 1'b0);
    slow_tick = 1'b1;
    wait_start(4, 1'b0);
    wr(`SCT_ADDR_SLOW_CLK, 16'h2692);
    clk_chk(2, 1'b1);
    slow_osc = 1'b0;
    clk_chk(2, 1'b0);
    slow_tick = 1'b1;
    wait_start(3, 1'b1);
    test_end("enable");
    // pin zero, pin one and reserved trigger sources in turn
    wr(`SCT_ADDR_PIN_CTRL, 16'h2096);
    slow_tick = 1'b1;
    wait_start(4, 1'b0);
    pin0 = 1'b1;
    wait_start(6, 1'b1);
    pin0 = 1'b0;
    wr(`SCT_ADDR_PIN_CTRL, 16'h20BA);
    repeat (4) @(negedge clock_in);
    pin1 = 1'b1;
    wait_start(6, 1'b1);
    pin1 = 1'b0;
    wr(`SCT_ADDR_PIN_CTRL, 16'h20BE);
    repeat (4) @(negedge clock_in);
    pin0 = 1'b1;
    pin1 = 1'b1;
    wait_start(6, 1'b0);
    pin0 = 1'b0;
    pin1 = 1'b0;
    test_end("trigger");
    // bypass takes the pin one level while its input is enabled, low otherwise, and ignores the internal clock
    wr(`SCT_ADDR_PIN_CTRL, 16'h20B0);
    wr(`SCT_ADDR_SLOW_CLK, 16'h2792);
    pin1 = 1'b1;
    clk_chk(5, 1'b1);
    pin1 = 1'b0;
    slow_osc = 1'b1;
    clk_chk(5, 1'b0);
    wr(`SCT_ADDR_PIN_CTRL, 16'h20D0);
    chk({16'h0000, oe_n}, 17'h00000);
    chk({16'h0000, pin1_drv}, 17'h00000);
    pin1 = 1'b1;
    clk_chk(5, 1'b0);
    wr(`SCT_ADDR_PIN_CTRL, 16'h2090);
    chk({16'h0000, oe_n}, 17'h00001);
    test_end("bypass");
    report_and_stop();
  end
endmodule : sct_bench
